/* File: hw/uscf_top.sv */
// Serial port clock generation and frame formatting
`timescale 1ns/100ps
// Contract
// - Baud down-counter reloads divisor at zero or on low-byte write.
// - One generator pulse per zero; rate is clock over divisor plus one.
// - Transmit divides generator by 16 normal, 8 double, 2 sync master.
// - Receive recovery steps 16 or 8 states by double speed; held at reset in sync.
// - Divisor is 12 bits from high and low bytes, 0 to 4095.
// - Double speed acts only in async; software clears it in sync.
// - Double speed receiver uses 8 recovery states per bit, not 16, with one sample at mid.
// - Slave clock synchronised and edge detected; peer keeps it below fosc/4.
// - Clock pin is input in slave, output in master, unused async.
// - Sync receive samples on the edge opposite the transmit change.
// - Polarity 0 changes on rise samples fall; 1 the reverse.
// - Frame: start, 5 to 9 data, optional parity, 1 or 2 stop.
// - Order start, data LSB first, parity, stops; back to back allowed.
// - Start low, stop high, idle line high.
// - Size field 3 bits, parity mode 2 bits, one stop select bit.
// - Receiver ignores second stop; framing error only on first stop zero.
// - Transmitter and receiver share one format setting.
// - Parity is XOR of data, inverted for odd, before first stop.
// - In sync, pin direction selects master or slave clock.
// - Size value seven selects nine bits; ninth from separate bit.
// - Parity enabled when upper parity mode bit is one.
module uscf_top
  import uscf_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       baud_divisor_high,
  input  wire logic [7:0]       baud_divisor_low,
  input  wire logic             baud_divisor_low_wr,
  input  wire logic             double_speed_select,
  input  wire logic             sync_mode_select,
  input  wire logic             clock_pin_direction,
  input  wire logic             clock_polarity_select,
  input  wire logic [2:0]       char_size_field,
  input  wire logic [1:0]       parity_mode_field,
  input  wire logic             stop_bits_select,
  input  wire logic             tx_enable,
  input  wire logic             rx_enable,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_bit8,
  input  wire logic             tx_start,
  input  wire logic             serial_in_pin,
  input  wire logic             transfer_clock_pin_in,
  output logic                  transfer_clock_pin_out,
  output logic                  transfer_clock_pin_oe,
  output logic                  serial_out_pin,
  output logic                  tx_busy,
  output logic                  tx_done,
  output logic [CHAR_W-1:0]     rx_data,
  output logic                  rx_valid,
  output logic                  framing_error_flag,
  output logic                  parity_error
);

  // ============================================================
  // Mode and shared format
  uscf_clk_mode_t   mode;
  logic [DIV_W-1:0] div;
  logic             baud_tick;
  logic             x_rise;
  logic             x_fall;
  logic             rxd_meta_ff;
  logic             rxd_ff;
  logic [3:0]       nbits;
  logic             par_en;
  logic             par_odd;

  assign div     = {baud_divisor_high, baud_divisor_low};
  assign nbits   = uscf_nbits(char_size_field);
  assign par_en  = parity_mode_field[PAR_EN_BIT];
  assign par_odd = parity_mode_field[PAR_ODD_BIT];

  always_comb begin
    if (!sync_mode_select) begin
      mode = double_speed_select ? USCF_CLK_ASYNC_2X : USCF_CLK_ASYNC;
    end else if (clock_pin_direction) begin
      mode = USCF_CLK_MASTER;
    end else begin
      mode = USCF_CLK_SLAVE;
    end
  end

  uscf_baud_gen u_baud (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .baud_divisor        (div),
    .baud_divisor_low_wr (baud_divisor_low_wr),
    .baud_tick           (baud_tick)
  );

  uscf_xck_sync u_xck (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (transfer_clock_pin_in),
    .rise    (x_rise),
    .fall    (x_fall),
    .level   ()
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_ff <= 1'b1;
      rxd_ff      <= 1'b1;
    end else begin
      rxd_meta_ff <= serial_in_pin;
      rxd_ff      <= rxd_meta_ff;
    end
  end

  // ============================================================
  // Transmit clock: async prescale, master clock toggle
  logic [3:0] tx_pre_ff;
  logic       xck_ff;
  logic       tx_step;
  logic       rx_sync_sample;
  logic       xck_shift_edge;
  logic       xck_sample_edge;
  logic       m_rise;
  logic       m_fall;
  logic [3:0] tx_div_m1;

  assign tx_div_m1 = (mode == USCF_CLK_ASYNC_2X) ? 4'(DIV_DOUBLE - 5'h01)
                                                : 4'(DIV_NORMAL - 5'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pre_ff <= PH_RST;
    end else if (baud_tick && !sync_mode_select) begin
      tx_pre_ff <= (tx_pre_ff >= tx_div_m1) ? PH_RST : tx_pre_ff + 4'h1;
    end
  end

  // Master clock: toggles per tick, a full period every 2 ticks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xck_ff <= 1'b0;
    end else if (mode != USCF_CLK_MASTER) begin
      xck_ff <= 1'b0;
    end else if (baud_tick) begin
      xck_ff <= ~xck_ff;
    end
  end

  assign m_rise = (mode == USCF_CLK_MASTER) && baud_tick && !xck_ff;
  assign m_fall = (mode == USCF_CLK_MASTER) && baud_tick && xck_ff;

  always_comb begin
    xck_shift_edge  = 1'b0;
    xck_sample_edge = 1'b0;
    if (mode == USCF_CLK_MASTER) begin
      // Pin already carries the polarity inversion
      xck_shift_edge  = m_rise;
      xck_sample_edge = m_fall;
    end else if (mode == USCF_CLK_SLAVE) begin
      xck_shift_edge  = clock_polarity_select ? x_fall : x_rise;
      xck_sample_edge = clock_polarity_select ? x_rise : x_fall;
    end
  end

  assign tx_step = sync_mode_select ? xck_shift_edge
                                    : (baud_tick && tx_pre_ff == tx_div_m1);
  assign rx_sync_sample = xck_sample_edge;

  // Pin drives only as master clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_clock_pin_out <= 1'b0;
      transfer_clock_pin_oe  <= 1'b0;
    end else begin
      transfer_clock_pin_out <= xck_ff ^ clock_polarity_select;
      transfer_clock_pin_oe  <= (mode == USCF_CLK_MASTER);
    end
  end

  // ============================================================
  // Transmitter
  uscf_state_t       tx_st_ff;
  logic [CHAR_W-1:0] tx_sh_ff;
  logic [3:0]        tx_cnt_ff;
  logic              tx_par_ff;
  logic              tx_pend_ff;
  logic [CHAR_W-1:0] tx_word;
  logic              tx_last;
  logic              tx_load;

  assign tx_word = {tx_bit8, tx_data};
  // Reload straight from the last stop keeps back-to-back frames gapless
  assign tx_last = (tx_st_ff == USCF_STOP2) || (tx_st_ff == USCF_STOP1 && !stop_bits_select);
  assign tx_load = tx_step && tx_pend_ff && (tx_st_ff == USCF_IDLE || tx_last);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pend_ff <= 1'b0;
    end else if (tx_start && tx_enable) begin
      tx_pend_ff <= 1'b1;
    end else if (tx_load) begin
      tx_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff  <= USCF_IDLE;
      tx_sh_ff  <= '0;
      tx_cnt_ff <= CNT_RST;
      tx_par_ff <= 1'b0;
    end else if (tx_load) begin
      tx_st_ff  <= USCF_START;
      tx_sh_ff  <= tx_word;
      tx_par_ff <= uscf_parity(tx_word, nbits, par_odd);
    end else if (tx_step) begin
      case (tx_st_ff)
        USCF_START: begin
          tx_st_ff  <= USCF_DATA;
          tx_cnt_ff <= CNT_RST;
        end
        USCF_DATA: begin
          tx_sh_ff  <= tx_sh_ff >> 1;
          tx_cnt_ff <= tx_cnt_ff + 4'h1;
          if (tx_cnt_ff == nbits - 4'h1) begin
            tx_st_ff <= par_en ? USCF_PARITY : USCF_STOP1;
          end
        end
        USCF_PARITY: begin
          tx_st_ff <= USCF_STOP1;
        end
        USCF_STOP1: begin
          tx_st_ff <= stop_bits_select ? USCF_STOP2 : USCF_IDLE;
        end
        default: begin
          tx_st_ff <= USCF_IDLE;
        end
      endcase
    end
  end

  // Line level per state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_pin <= 1'b1;
    end else begin
      case (tx_st_ff)
        USCF_START:  serial_out_pin <= 1'b0;
        USCF_DATA:   serial_out_pin <= tx_sh_ff[0];
        USCF_PARITY: serial_out_pin <= tx_par_ff;
        default:     serial_out_pin <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_busy <= (tx_st_ff != USCF_IDLE) || tx_pend_ff;
      tx_done <= tx_step && !tx_pend_ff && tx_last;
    end
  end

  // ============================================================
  // Receiver: recovery phase runs on undivided ticks
  uscf_state_t       rx_st_ff;
  logic [3:0]        rx_ph_ff;
  logic [3:0]        rx_cnt_ff;
  logic [CHAR_W-1:0] rx_sh_ff;
  logic [3:0]        rx_last;
  logic [3:0]        rx_mid;
  logic              rx_bit_pt;
  logic              rx_in;

  assign rx_last = (mode == USCF_CLK_ASYNC_2X) ? 4'(DIV_DOUBLE - 5'h01)
                                               : 4'(DIV_NORMAL - 5'h01);
  assign rx_mid  = (mode == USCF_CLK_ASYNC_2X) ? MID_DOUBLE : MID_NORMAL;
  assign rx_in   = rxd_ff;

  // Async: one sample at phase mid; sync: sample edge
  assign rx_bit_pt = sync_mode_select ? rx_sync_sample
                                      : (baud_tick && rx_ph_ff == rx_mid);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ph_ff <= PH_RST;
    end else if (sync_mode_select || (rx_st_ff == USCF_IDLE && rx_in)) begin
      rx_ph_ff <= PH_RST;
    end else if (baud_tick) begin
      rx_ph_ff <= (rx_ph_ff >= rx_last) ? PH_RST : rx_ph_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff           <= USCF_IDLE;
      rx_cnt_ff          <= CNT_RST;
      rx_sh_ff           <= '0;
      rx_data            <= '0;
      rx_valid           <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error       <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_enable) begin
        rx_st_ff <= USCF_IDLE;
      end else if (rx_bit_pt) begin
        case (rx_st_ff)
          USCF_IDLE: begin
            // False start rejected when line is back high
            if (!rx_in) begin
              rx_st_ff  <= USCF_DATA;
              rx_cnt_ff <= CNT_RST;
              rx_sh_ff  <= '0;
            end
          end
          USCF_DATA: begin
            rx_sh_ff[rx_cnt_ff] <= rx_in;
            rx_cnt_ff           <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == nbits - 4'h1) begin
              rx_st_ff <= par_en ? USCF_PARITY : USCF_STOP1;
            end
          end
          USCF_PARITY: begin
            parity_error <= rx_in != uscf_parity(rx_sh_ff, nbits, par_odd);
            rx_st_ff     <= USCF_STOP1;
          end
          default: begin
            // Second stop never checked
            framing_error_flag <= !rx_in;
            rx_data            <= rx_sh_ff;
            rx_valid           <= 1'b1;
            if (!par_en) begin
              parity_error <= 1'b0;
            end
            rx_st_ff <= USCF_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: hw/uscf_pkg.sv */
// Package: constants and types for the serial clock and frame block
package uscf_pkg;

  // ============================================================
  // Widths
  localparam int unsigned DIV_W   = 12;
  localparam int unsigned CHAR_W  = 9;

  // ============================================================
  // Reset values
  localparam logic [DIV_W-1:0] DIV_RST   = 12'h000;
  localparam logic [3:0]       PH_RST    = 4'h0;
  localparam logic [3:0]       CNT_RST   = 4'h0;

  // ============================================================
  // Clock division per mode
  localparam logic [4:0] DIV_NORMAL = 5'h10;
  localparam logic [4:0] DIV_DOUBLE = 5'h08;
  localparam logic [4:0] DIV_SYNC   = 5'h02;

  // ============================================================
  // Frame format encodings
  localparam logic [2:0] CSZ_NINE     = 3'h7;
  localparam int unsigned PAR_EN_BIT  = 1;
  localparam int unsigned PAR_ODD_BIT = 0;

  // Sample point within a bit, counted in recovery states
  localparam logic [3:0] MID_NORMAL = 4'h7;
  localparam logic [3:0] MID_DOUBLE = 4'h3;

  typedef enum logic [1:0] {
    USCF_CLK_ASYNC,
    USCF_CLK_ASYNC_2X,
    USCF_CLK_MASTER,
    USCF_CLK_SLAVE
  } uscf_clk_mode_t;

  typedef enum logic [2:0] {
    USCF_IDLE,
    USCF_START,
    USCF_DATA,
    USCF_PARITY,
    USCF_STOP1,
    USCF_STOP2
  } uscf_state_t;

  // Number of data bits from the character size field
  function automatic logic [3:0] uscf_nbits(input logic [2:0] csz);
    if (csz == CSZ_NINE) begin
      uscf_nbits = 4'h9;
    end else if (csz > 3'h3) begin
      uscf_nbits = 4'h8;
    end else begin
      uscf_nbits = {1'b0, csz} + 4'h5;
    end
  endfunction

  // Parity over the valid data bits
  function automatic logic uscf_parity(input logic [CHAR_W-1:0] d,
                                       input logic [3:0] n,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < CHAR_W; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    uscf_parity = p;
  endfunction

endpackage

/* File: hw/uscf_baud_gen.sv */
// Baud down-counter producing one-cycle generator pulses
`timescale 1ns/100ps
module uscf_baud_gen
  import uscf_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             baud_divisor_low_wr,
  output logic                  baud_tick
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;

  // ============================================================
  // Down-counter
  always_comb begin
    if (baud_divisor_low_wr || cnt_ff == '0) begin
      nxt_cnt = baud_divisor;
    end else begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= DIV_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Pulse at zero gives fosc/(divisor+1)
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= (cnt_ff == '0) && !baud_divisor_low_wr;
    end
  end

endmodule

/* File: hw/uscf_xck_sync.sv */
// Transfer clock pin synchroniser and edge detector
`timescale 1ns/100ps
module uscf_xck_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall,
  output logic      level
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ============================================================
  // Two stages, then edge detect on the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;
  assign level = sync_ff;

endmodule

/* File: tb/uscf_sva.sv */
// Checker: timing relations at the ports of the serial clock and frame block
`timescale 1ns/100ps
module uscf_sva
  import uscf_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              double_speed_select,
  input wire logic              sync_mode_select,
  input wire logic              clock_pin_direction,
  input wire logic [1:0]        parity_mode_field,
  input wire logic              transfer_clock_pin_oe,
  input wire logic              serial_out_pin,
  input wire logic              tx_done,
  input wire logic [CHAR_W-1:0] rx_data,
  input wire logic              rx_valid,
  input wire logic              framing_error_flag,
  input wire logic              parity_error
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ============================================================
  // Clock pin and transmit line
  // Guarded by past reset: inputs seen during reset never reach the register
  property p_oe_mode;
    $past(rst_n) |-> transfer_clock_pin_oe == ($past(sync_mode_select) && $past(clock_pin_direction));
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("clock pin enable wrong for mode");

  property p_lo_min;
    $fell(serial_out_pin) && !sync_mode_select |-> !serial_out_pin [*8];
  endproperty
  a_lo_min: assert property (p_lo_min) else $error("async low bit shorter than 8");

  property p_lo_norm;
    $fell(serial_out_pin) && !sync_mode_select && !double_speed_select
      |-> !serial_out_pin [*8] ##1 !serial_out_pin [*8];
  endproperty
  a_lo_norm: assert property (p_lo_norm) else $error("normal low bit shorter than 16");

  property p_hi_norm;
    $rose(serial_out_pin) && !sync_mode_select && !double_speed_select
      |-> serial_out_pin [*8] ##1 serial_out_pin [*8];
  endproperty
  a_hi_norm: assert property (p_hi_norm) else $error("normal high bit shorter than 16");

  property p_done_hi;
    tx_done |-> serial_out_pin && $past(serial_out_pin);
  endproperty
  a_done_hi: assert property (p_done_hi) else $error("frame ended without high stop");

  // ============================================================
  // Receive results
  property p_fe_hold;
    !rx_valid |-> $stable(framing_error_flag);
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing flag moved without frame");

  property p_rxd_hold;
    !rx_valid |-> $stable(rx_data);
  endproperty
  a_rxd_hold: assert property (p_rxd_hold) else $error("receive data moved without frame");

  property p_no_par;
    rx_valid && !parity_mode_field[1] |-> !parity_error;
  endproperty
  a_no_par: assert property (p_no_par) else $error("parity error with parity off");
endmodule

bind uscf_top uscf_sva chk_i (.*);

/* File: tb/uscf_peer.sv */
// Remote serial peer: frame sender and frame catcher on the data pins
`timescale 1ns/100ps
module uscf_peer (
  input  wire logic sys_clk,
  input  wire logic line_in,
  input  wire logic xck_in,
  input  wire logic pol,
  input  wire logic sync,
  output logic      line_out
);
  // ============================================================
  // Line control
  initial line_out = 1'b1;

  task automatic tk;
    @(posedge sys_clk);
    #2;
  endtask

  // Sample point: a count of cycles, or the clock edge opposite the change edge
  task automatic step(input int per);
    logic xp;
    if (!sync) begin
      repeat (per) tk();
    end else begin
      for (int k = 0; k < 1100; k++) begin
        xp = xck_in ^ pol;
        tk();
        if (xp && !(xck_in ^ pol)) break;
      end
    end
  endtask

  // Bits leave lowest index first; line returns high afterwards
  task automatic send(input logic [12:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      line_out = f[i];
      repeat (per) tk();
    end
    line_out = 1'b1;
  endtask

  // Bounded hunt for the start bit; a silent line returns all ones
  task automatic recv(input int n, input int per, output logic [12:0] f);
    f = '1;
    for (int k = 0; k < 600 && line_in; k++) step(1);
    if (!sync) repeat (per / 2) tk();
    for (int i = 0; i < n; i++) begin
      if (i > 0) step(per);
      f[i] = line_in;
    end
  endtask
endmodule

/* File: tb/uscf_top_tb.sv */
// Testbench: frame, rate and clock pin scenarios for the serial block
`timescale 1ns/100ps
module uscf_top_tb;
  import uscf_pkg::*;
  logic              sys_clk, rst_n, baud_divisor_low_wr, double_speed_select;
  logic              sync_mode_select, clock_pin_direction, clock_polarity_select;
  logic              stop_bits_select, tx_enable, rx_enable, tx_bit8, tx_start;
  logic              serial_in_pin, transfer_clock_pin_in, transfer_clock_pin_out;
  logic              transfer_clock_pin_oe, serial_out_pin, tx_busy, tx_done;
  logic              rx_valid, framing_error_flag, parity_error;
  logic [3:0]        baud_divisor_high;
  logic [7:0]        baud_divisor_low, tx_data;
  logic [2:0]        char_size_field;
  logic [1:0]        parity_mode_field;
  logic [CHAR_W-1:0] rx_data;
  int                error_cnt, n_checks, per;

  uscf_top dut (.*);
  uscf_peer peer (
    .sys_clk (sys_clk),
    .line_in (serial_out_pin),
    .xck_in  (transfer_clock_pin_oe ? transfer_clock_pin_out : transfer_clock_pin_in),
    .pol     (clock_polarity_select),
    .sync    (sync_mode_select),
    .line_out(serial_in_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ============================================================
  // Shared tasks
  task automatic tk(input int c = 1);
    repeat (c) @(posedge sys_clk);
    #2;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic [2:0] c, input logic [1:0] p, input logic s, ds, sm, pl,
                     input logic [11:0] dv);
    char_size_field = c;
    parity_mode_field = p;
    stop_bits_select = s;
    double_speed_select = ds;
    sync_mode_select = sm;
    clock_pin_direction = sm;
    clock_polarity_select = pl;
    {baud_divisor_high, baud_divisor_low} = dv;
    baud_divisor_low_wr = 1'b1;
    tk();
    baud_divisor_low_wr = 1'b0;
  endtask

  // Expected frame from the current format fields
  task automatic mk(input logic [8:0] d, output logic [12:0] f, output int n);
    int nb;
    nb = (char_size_field == 3'h7) ? 9 : (char_size_field > 3'h3) ? 8 : char_size_field + 5;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    n = nb + 1;
    if (parity_mode_field[1]) begin
      f[n] = ^(d & ~(9'h1ff << nb)) ^ parity_mode_field[0];
      n++;
    end
    n += 1 + stop_bits_select;
  endtask

  task automatic pulse;
    tx_start = 1'b1;
    tk();
    tx_start = 1'b0;
  endtask

  task automatic idle;
    int d;
    d = 0;
    for (int k = 0; k < 3000 && tx_busy; k++) begin
      tk();
      d += int'(tx_done);
    end
    chk(tx_busy, 1'b0);
    chk(13'(d), 13'h1);
  endtask

  task automatic tx_one(input logic [8:0] d);
    logic [12:0] f, g;
    int n;
    mk(d, f, n);
    tx_data = d[7:0];
    tx_bit8 = d[8];
    pulse();
    peer.recv(n, per, g);
    chk(g & ~(13'h1fff << n), f & ~(13'h1fff << n));
  endtask

  task automatic wait_rx;
    for (int k = 0; k < 400 && !rx_valid; k++) tk();
    chk(rx_valid, 1'b1);
  endtask

  // ============================================================
  // Scenarios
  task automatic s_formats;
    logic [1:0] pm [3] = '{2'h0, 2'h2, 2'h3};
    per = 16;
    for (int i = 0; i < 8; i++) begin
      cfg(3'(i), pm[i % 3], 1'(i), 1'b0, 1'b0, 1'b0, 12'h000);
      tx_one(9'h0a5 ^ 9'(i * 37));
      idle();
    end
  endtask

  // Second request queued mid-frame follows without a gap, double speed
  task automatic s_b2b;
    logic [12:0] f, g;
    int n;
    cfg(3'h3, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 12'h000);
    per = 8;
    mk(9'h03c, f, n);
    tx_data = 8'h3c;
    pulse();
    fork
      peer.recv(n, per, g);
      begin
        tk(20);
        tx_data = 8'hc3;
        pulse();
      end
    join
    chk(g, f);
    tk(5);
    chk(serial_out_pin, 1'b0);
    peer.recv(n, per, g);
    mk(9'h0c3, f, n);
    chk(g, f);
    idle();
  endtask

  task automatic s_rate;
    cfg(3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 12'h002);
    per = 48;
    tx_enable = 1'b0;
    pulse();
    tk(40);
    chk(tx_busy, 1'b0);
    tx_enable = 1'b1;
    tx_one(9'h05a);
    idle();
  endtask

  // Master clock on the pin, both polarities; large divisor uses the high nibble
  task automatic s_sync;
    for (int pl = 0; pl < 2; pl++) begin
      cfg(3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'(pl), 12'h100);
      tk(2);
      chk(transfer_clock_pin_oe, 1'b1);
      tx_one(9'h0b4);
      idle();
    end
    cfg(3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000);
    tk(2);
    chk(transfer_clock_pin_oe, 1'b0);
  endtask

  // Slave clock from the far side, 16-cycle period, well below a quarter of the clock
  task automatic s_slave;
    cfg(3'h3, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000);
    clock_pin_direction = 1'b0;
    tk(2);
    chk(transfer_clock_pin_oe, 1'b0);
    fork
      begin
        tx_one(9'h0e1);
        idle();
      end
      for (int k = 0; k < 80; k++) begin
        tk(8);
        transfer_clock_pin_in = ~transfer_clock_pin_in;
      end
    join
  endtask

  // Good, bad parity, bad first stop, bad second stop, double speed
  task automatic s_rx;
    logic [12:0] f;
    int n;
    for (int c = 0; c < 5; c++) begin
      cfg(3'h7, (c == 3) ? 2'h0 : 2'h3, 1'b1, c == 4, 1'b0, 1'b0, 12'h000);
      per = (c == 4) ? 8 : 16;
      mk(9'h1c6, f, n);
      if (c == 1) f[10] = ~f[10];
      if (c == 2) f[n-2] = 1'b0;
      if (c == 3) f[n-1] = 1'b0;
      fork
        peer.send(f, n, per);
        wait_rx();
      join
      chk(rx_data, 9'h1c6);
      chk(framing_error_flag, c == 2);
      chk(parity_error, c == 1);
      tk(250);
    end
  endtask

  initial begin
    {rst_n, baud_divisor_low_wr, double_speed_select, sync_mode_select, clock_pin_direction,
     clock_polarity_select, stop_bits_select, tx_bit8, tx_start, transfer_clock_pin_in,
     baud_divisor_high, baud_divisor_low, tx_data, char_size_field, parity_mode_field} = '0;
    {tx_enable, rx_enable} = 2'h3;
    error_cnt = 0;
    n_checks = 0;
    per = 16;
    tk(6);
    rst_n = 1'b1;
    chk(serial_out_pin, 1'b1);
    s_formats();
    s_b2b();
    s_rate();
    s_sync();
    s_slave();
    s_rx();
    close_out();
  end
endmodule
